// [common/pmon_pkg.sv]
package pmon_pkg;
  localparam int unsigned CLK_PERIOD_NS      = 25;
  localparam int unsigned CYC_PER_US_DEF     = 1000 / CLK_PERIOD_NS;
  localparam int unsigned DELAY_STEP_MS      = 2;
  localparam int unsigned DELAY_MAX_MS       = 510;
  localparam int unsigned DELAY_STEP_CYC_DEF = DELAY_STEP_MS * 1000000 / CLK_PERIOD_NS;
  localparam int unsigned CT_MIN_US          = 50;
  localparam int unsigned CT_MAX_US          = 4120;
  // Conversion period per code in microseconds, code 7 first.
  localparam logic [7:0][12:0] CT_US = {13'h1018, 13'h081A, 13'h041C, 13'h021C,
                                        13'h0118, 13'h0096, 13'h0054, 13'h0032};
  // Averaging count per code as a power of two: 1, 4, 16, 64, 128, 256, 512, 1024.
  localparam logic [7:0][3:0] AVG_SHIFT = {4'hA, 4'h9, 4'h8, 4'h7, 4'h6, 4'h4, 4'h2, 4'h0};
  localparam int unsigned TC_SHIFT      = 20;
  localparam int unsigned MODE_CONT_BIT = 2;
  localparam int unsigned MODE_CUR_BIT  = 1;
  localparam int unsigned MODE_BUS_BIT  = 0;

  typedef enum logic [2:0] {
    MODE_SHDN_A   = 3'h0,
    MODE_TRIG_BUS = 3'h1,
    MODE_TRIG_CUR = 3'h2,
    MODE_TRIG_ALL = 3'h3,
    MODE_SHDN_B   = 3'h4,
    MODE_CONT_BUS = 3'h5,
    MODE_CONT_CUR = 3'h6,
    MODE_CONT_ALL = 3'h7
  } mode_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_DELAY = 3'h1,
    ST_TEMP  = 3'h2,
    ST_SHUNT = 3'h3,
    ST_BUS   = 3'h4,
    ST_WRAP  = 3'h5
  } st_t;

  typedef enum logic [1:0] {
    CH_NONE  = 2'h0,
    CH_TEMP  = 2'h1,
    CH_SHUNT = 2'h2,
    CH_BUS   = 2'h3
  } chan_t;

  typedef struct packed {
    mode_t      mode;
    logic [2:0] avg;
    logic [2:0] bus_ct;
    logic [2:0] sh_ct;
    logic [2:0] tmp_ct;
  } cfg_t;

  typedef struct packed {
    logic [15:0] current;
    logic [15:0] vbus;
    logic [15:0] temp;
  } meas_t;

  localparam cfg_t CFG_RST = '{mode: MODE_CONT_ALL, avg: 3'h0, bus_ct: 3'h5,
                               sh_ct: 3'h5, tmp_ct: 3'h5};
endpackage : pmon_pkg

// [verilog/calc_engine.sv]
`timescale 1ns/1ps
`default_nettype none
module calc_engine
  import pmon_pkg::*;
(
  input  wire logic        ref_clk_i,
  input  wire logic        srst_i,
  input  wire logic        acc_clr_i,
  input  wire logic        shunt_go_i,
  input  wire logic [15:0] shunt_raw_i,
  input  wire logic [15:0] temp_i,
  input  wire logic        bus_go_i,
  input  wire logic [15:0] vbus_i,
  input  wire logic [15:0] cur_prev_i,
  output logic      [15:0] cur_corr_o,
  output logic      [47:0] energy_o,
  output logic      [47:0] charge_o
);
  typedef struct packed {
    logic [47:0] energy;
    logic [47:0] charge;
  } calc_state_t;

  calc_state_t s;
  calc_state_t n;
  logic [31:0] tc_prod;
  logic [31:0] tc_corr;
  logic [31:0] p_inst;

  // Temperature correction of the raw shunt result, ready in the same cycle.
  always_comb begin
    tc_prod = 32'($signed(shunt_raw_i) * $signed(temp_i));
    tc_corr = 32'($signed(tc_prod) >>> TC_SHIFT);
    cur_corr_o = 16'(shunt_raw_i - tc_corr[15:0]);
    p_inst = 32'($signed(vbus_i) * $signed(cur_prev_i));
  end

  // Charge grows at each shunt conversion end, energy at each bus conversion end, next to the sequencer.
  always_comb begin
    n = s;
    if (shunt_go_i) begin
      n.charge = s.charge + 48'($signed(cur_corr_o));
    end
    if (bus_go_i) begin
      n.energy = s.energy + 48'($signed(p_inst));
    end
    if (acc_clr_i) begin
      n = '0;
    end
  end

  // State register.
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign energy_o = s.energy;
  assign charge_o = s.charge;
endmodule : calc_engine
`default_nettype wire

// [verilog/power_monitor_conversion_sequencer.sv]
`timescale 1ns/1ps
`default_nettype none
module power_monitor_conversion_sequencer
  import pmon_pkg::*;
#(
  parameter int unsigned CYC_PER_US     = CYC_PER_US_DEF,
  parameter int unsigned DELAY_STEP_CYC = DELAY_STEP_CYC_DEF
) (
  input  wire logic        ref_clk_i,
  input  wire logic        srst_i,
  input  wire logic        cfg_wr_i,
  input  wire cfg_t        cfg_i,
  input  wire logic [7:0]  start_delay_field_i,
  input  wire logic        diag_rd_i,
  input  wire logic        done_to_alert_enable_i,
  input  wire logic [15:0] adc_result_i,
  output meas_t            meas_o,
  output logic      [31:0] power_o,
  output logic      [47:0] energy_o,
  output logic      [47:0] charge_o,
  output logic             accum_valid_o,
  output logic             conversion_done_flag_o,
  output logic             alert_o,
  output chan_t            adc_chan_o,
  output logic             adc_start_o,
  output logic      [2:0]  adc_ct_o,
  output logic             busy_o
);
  typedef struct packed {
    st_t         st;
    cfg_t        cfg;
    logic [7:0]  dly;
    logic [23:0] step;
    logic [17:0] tmr;
    logic [10:0] smp;
    logic [25:0] acc_c;
    logic [25:0] acc_v;
    logic [25:0] acc_t;
    logic [15:0] t_last;
    meas_t       meas;
    logic [31:0] pwr;
    logic        done;
    logic        alert;
    logic        acc_ok;
    logic        start;
    chan_t       chan;
    logic [2:0]  ct;
    logic        busy;
  } state_t;

  state_t      s;
  state_t      n;
  logic        last;
  logic        done_set;
  logic        shunt_go;
  logic        bus_go;
  logic        acc_clr;
  logic [15:0] cur_corr;

  // Timer load for one conversion period of the given code: its cycle count minus one.
  function automatic logic [17:0] ct_cycles(input logic [2:0] code);
    ct_cycles = 18'(CT_US[code] * CYC_PER_US - 1);
  endfunction : ct_cycles

  // Starts one conversion on a channel and tells the converter its period.
  function automatic state_t load_conv(input state_t x, input st_t st,
                                       input chan_t ch, input logic [2:0] ct);
    state_t r;
    r = x;
    r.st = st;
    r.chan = ch;
    r.ct = ct;
    r.tmr = ct_cycles(ct);
    r.start = 1'b1;
    r.busy = 1'b1;
    return r;
  endfunction : load_conv

  // First conversion of a sequence: temperature if current is on, else bus.
  function automatic state_t begin_seq(input state_t x);
    state_t r;
    if (x.cfg.mode[MODE_CUR_BIT]) begin
      r = load_conv(x, ST_TEMP, CH_TEMP, x.cfg.tmp_ct);
    end else begin
      r = load_conv(x, ST_BUS, CH_BUS, x.cfg.bus_ct);
    end
    return r;
  endfunction : begin_seq

  // Temperature correction and accumulation of energy and charge.
  calc_engine u_calc (
    .ref_clk_i   (ref_clk_i),
    .srst_i      (srst_i),
    .acc_clr_i   (acc_clr),
    .shunt_go_i  (shunt_go),
    .shunt_raw_i (adc_result_i),
    .temp_i      (s.t_last),
    .bus_go_i    (bus_go),
    .vbus_i      (adc_result_i),
    .cur_prev_i  (s.meas.current),
    .cur_corr_o  (cur_corr),
    .energy_o    (energy_o),
    .charge_o    (charge_o)
  );

  // Sequencer: delay, conversions in turn, averaging and result loading.
  always_comb begin
    n = s;
    n.start = 1'b0;
    shunt_go = 1'b0;
    bus_go = 1'b0;
    acc_clr = 1'b0;
    done_set = 1'b0;
    last = (s.smp + 11'h001) == (11'h001 << AVG_SHIFT[s.cfg.avg]);
    case (s.st)
      ST_IDLE: begin
        n.busy = 1'b0;
        n.chan = CH_NONE;
      end
      ST_DELAY: begin
        if (s.dly == 8'h00) begin
          n = begin_seq(s);
        end else if (s.step == 24'(DELAY_STEP_CYC - 1)) begin
          n.step = '0;
          n.dly = s.dly - 8'h01;
        end else begin
          n.step = s.step + 24'h00_0001;
        end
      end
      ST_TEMP: begin
        if (s.tmr == '0) begin
          n.t_last = adc_result_i;
          if (s.cfg.avg == 3'h0) begin
            n.meas.temp = adc_result_i;
          end else begin
            n.acc_t = s.acc_t + 26'($signed(adc_result_i));
          end
          n = load_conv(n, ST_SHUNT, CH_SHUNT, s.cfg.sh_ct);
        end else begin
          n.tmr = s.tmr - 18'h0_0001;
        end
      end
      ST_SHUNT: begin
        if (s.tmr == '0) begin
          shunt_go = 1'b1;
          if (s.cfg.avg == 3'h0) begin
            n.meas.current = cur_corr;
          end else begin
            n.acc_c = s.acc_c + 26'($signed(cur_corr));
          end
          if (s.cfg.mode[MODE_BUS_BIT]) begin
            n = load_conv(n, ST_BUS, CH_BUS, s.cfg.bus_ct);
          end else begin
            n.st = ST_WRAP;
            n.chan = CH_NONE;
          end
        end else begin
          n.tmr = s.tmr - 18'h0_0001;
        end
      end
      ST_BUS: begin
        if (s.tmr == '0) begin
          bus_go = 1'b1;
          if (s.cfg.avg == 3'h0) begin
            n.meas.vbus = adc_result_i;
          end else begin
            n.acc_v = s.acc_v + 26'($signed(adc_result_i));
          end
          n.st = ST_WRAP;
          n.chan = CH_NONE;
        end else begin
          n.tmr = s.tmr - 18'h0_0001;
        end
      end
      ST_WRAP: begin
        n.smp = s.smp + 11'h001;
        if (!last) begin
          n = begin_seq(n);
        end else begin
          if (s.cfg.avg != 3'h0) begin
            if (s.cfg.mode[MODE_CUR_BIT]) begin
              n.meas.current = 16'($signed(s.acc_c) >>> AVG_SHIFT[s.cfg.avg]);
              n.meas.temp = 16'($signed(s.acc_t) >>> AVG_SHIFT[s.cfg.avg]);
            end
            if (s.cfg.mode[MODE_BUS_BIT]) begin
              n.meas.vbus = 16'($signed(s.acc_v) >>> AVG_SHIFT[s.cfg.avg]);
            end
          end
          if (s.cfg.mode[MODE_BUS_BIT]) begin
            n.pwr = 32'($signed(n.meas.vbus) * $signed(n.meas.current));
          end
          done_set = 1'b1;
          n.smp = '0;
          n.acc_c = '0;
          n.acc_v = '0;
          n.acc_t = '0;
          if (s.cfg.mode[MODE_CONT_BIT]) begin
            n = begin_seq(n);
          end else begin
            n.st = ST_IDLE;
            n.busy = 1'b0;
          end
        end
      end
      default: begin
        n.st = ST_IDLE;
        n.busy = 1'b0;
        n.chan = CH_NONE;
      end
    endcase
    // A mode write aborts the run; a shutdown mode stops in idle, any other restarts from the delay countdown.
    if (cfg_wr_i) begin
      n.cfg = cfg_i;
      n.smp = '0;
      n.acc_c = '0;
      n.acc_v = '0;
      n.acc_t = '0;
      n.chan = CH_NONE;
      n.start = 1'b0;
      if (cfg_i.mode[MODE_CUR_BIT:MODE_BUS_BIT] == 2'h0) begin
        n.st = ST_IDLE;
        n.busy = 1'b0;
      end else begin
        n.st = ST_DELAY;
        n.dly = start_delay_field_i;
        n.step = '0;
        n.busy = 1'b1;
        n.done = 1'b0;
        acc_clr = 1'b1;
      end
    end
    // Clears lose to a completion in the same cycle.
    if (diag_rd_i) begin
      n.done = 1'b0;
    end
    if (done_set) begin
      n.done = 1'b1;
    end
    n.alert = done_to_alert_enable_i & n.done;
    n.acc_ok = n.cfg.mode[MODE_CONT_BIT];
  end

  // State register; after reset a continuous run starts with no delay.
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      s <= '0;
      s.st <= ST_DELAY;
      s.cfg <= CFG_RST;
      s.busy <= 1'b1;
      s.acc_ok <= 1'b1;
    end else begin
      s <= n;
    end
  end

  // Outputs come straight from the state register.
  assign meas_o = s.meas;
  assign power_o = s.pwr;
  assign accum_valid_o = s.acc_ok;
  assign conversion_done_flag_o = s.done;
  assign alert_o = s.alert;
  assign adc_chan_o = s.chan;
  assign adc_start_o = s.start;
  assign adc_ct_o = s.ct;
  assign busy_o = s.busy;

  // Assertions run on the sequencer clock and stay quiet during reset.
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (srst_i);

  sequence seq_launch;
    cfg_wr_i && (cfg_i.mode[MODE_CUR_BIT:MODE_BUS_BIT] != 2'h0);
  endsequence

  sequence seq_finish;
    (s.st == ST_WRAP) && last && !cfg_wr_i;
  endsequence

  sequence seq_temp_end;
    (s.st == ST_TEMP) && (s.tmr == '0) && !cfg_wr_i;
  endsequence

  sequence seq_shunt_end;
    (s.st == ST_SHUNT) && (s.tmr == '0) && !cfg_wr_i;
  endsequence

  sequence seq_bus_end;
    (s.st == ST_BUS) && (s.tmr == '0) && !cfg_wr_i;
  endsequence

  // Mode write, shutdown, completion and flag checks.
  restart_a: assert property (seq_launch |=> (s.st == ST_DELAY) && (s.dly == $past(start_delay_field_i)))
    else $error("Mode write did not restart the delay countdown.");
  shdn_write_a: assert property (cfg_wr_i && (cfg_i.mode[MODE_CUR_BIT:MODE_BUS_BIT] == 2'h0)
                                 |=> (s.st == ST_IDLE) && !s.busy)
    else $error("Shutdown write did not stop the sequencer.");
  done_set_a: assert property ($rose(s.done) |-> $past(s.st == ST_WRAP && last))
    else $error("Done flag rose without a finished sequence.");
  done_clear_a: assert property (((seq_launch or diag_rd_i) and (!(s.st == ST_WRAP && last))) |=> !s.done)
    else $error("Done flag survived a clearing access.");
  trig_stop_a: assert property ((seq_finish and (!s.cfg.mode[MODE_CONT_BIT])) |=> (s.st == ST_IDLE) && s.done)
    else $error("Triggered run did not stop after one sequence.");
  cont_loop_a: assert property ((seq_finish and (s.cfg.mode[MODE_CONT_BIT])) |=> s.start && s.busy && s.done)
    else $error("Continuous run did not restart.");
  temp_shunt_a: assert property (seq_temp_end |=> (s.st == ST_SHUNT) && (s.chan == CH_SHUNT) && s.start)
    else $error("Shunt conversion did not follow temperature.");
  hold_out_a: assert property (!cfg_wr_i && (s.cfg.avg != 3'h0) && (s.st != ST_WRAP) |=> $stable(s.meas))
    else $error("Averaged outputs changed before completion.");
  direct_bus_a: assert property ((s.cfg.avg == 3'h0) && (s.st == ST_BUS) && (s.tmr == '0) && !cfg_wr_i
                                 |=> s.meas.vbus == $past(adc_result_i))
    else $error("Single sample was not loaded directly.");
  delay_hold_a: assert property ((s.st == ST_DELAY) && (s.dly != 8'h00) && !cfg_wr_i |=> s.st == ST_DELAY)
    else $error("Conversion started before the delay expired.");
  alert_done_a: assert property (1'b1 |=> s.alert == ($past(done_to_alert_enable_i) && s.done))
    else $error("Alert does not follow done flag and enable.");

  // Conversion order, period and delay pacing checks.
  shunt_bus_a: assert property ((seq_shunt_end and (s.cfg.mode[MODE_BUS_BIT])) |=>
                                (s.st == ST_BUS) && (s.chan == CH_BUS) && s.start)
    else $error("Bus conversion did not follow the shunt conversion.");
  bus_wrap_a: assert property (seq_bus_end |=> (s.st == ST_WRAP) && (s.chan == CH_NONE) && !s.start)
    else $error("Bus conversion end did not reach the wrap step.");
  start_pulse_a: assert property (s.start |=> !s.start)
    else $error("Conversion start lasted more than one cycle.");
  count_down_a: assert property ((s.st inside {ST_TEMP, ST_SHUNT, ST_BUS}) && (s.tmr != '0) && !cfg_wr_i
                                 |=> (s.tmr == $past(s.tmr) - 18'h0_0001) && $stable(s.st))
    else $error("Conversion period did not count down.");
  ct_load_a: assert property (s.start |-> (s.tmr == ct_cycles(s.ct)) &&
                              (s.ct == ((s.chan == CH_TEMP) ? s.cfg.tmp_ct :
                                        (s.chan == CH_SHUNT) ? s.cfg.sh_ct : s.cfg.bus_ct)))
    else $error("Conversion period does not match its channel code.");
  idle_quiet_a: assert property ((s.st == ST_IDLE) && !cfg_wr_i
                                 |=> (s.st == ST_IDLE) && !s.busy && !s.start && (s.chan == CH_NONE))
    else $error("Stopped sequencer did not stay quiet.");
  acc_valid_a: assert property (s.acc_ok == s.cfg.mode[MODE_CONT_BIT])
    else $error("Accumulator valid does not follow the continuous mode.");
  delay_step_a: assert property ((s.st == ST_DELAY) && (s.dly != 8'h00) && !cfg_wr_i &&
                                 (s.step == 24'(DELAY_STEP_CYC - 1)) |=>
                                 (s.dly == $past(s.dly) - 8'h01) && (s.step == '0))
    else $error("Start delay did not step down once per delay step.");
  delay_first_a: assert property ((s.st == ST_DELAY) && (s.dly == 8'h00) && !cfg_wr_i
                                  |=> s.start && s.busy)
    else $error("Expired delay did not launch the first conversion.");
  acc_clear_a: assert property (cfg_wr_i |=> (s.smp == '0) && (s.acc_c == '0) &&
                                (s.acc_v == '0) && (s.acc_t == '0))
    else $error("Mode write did not clear the averaging run.");
  smp_clear_a: assert property (seq_finish |=> (s.smp == '0))
    else $error("Sample count did not restart after a finished run.");
  pwr_hold_a: assert property ((s.st == ST_WRAP) && !s.cfg.mode[MODE_BUS_BIT] |=> $stable(s.pwr))
    else $error("Power changed without a bus conversion.");
endmodule : power_monitor_conversion_sequencer
`default_nettype wire

// [test/adc_model.sv]
`timescale 1ns/1ps
`default_nettype none
module adc_model
  import pmon_pkg::*;
(
  input  wire logic        ref_clk_i,
  input  wire logic        srst_i,
  input  wire chan_t       adc_chan_i,
  input  wire logic        adc_start_i,
  input  wire logic        wobble_i,
  output logic      [15:0] adc_result_o
);
  logic [1:0]  step_reg;
  logic [15:0] last_reg;
  logic [15:0] offset;

  // One step per bus conversion start, so any four bus starts in a row add offsets 0 to 3 once each.
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      step_reg <= 2'h0;
      last_reg <= 16'h0000;
    end else begin
      if (adc_start_i && adc_chan_i == CH_BUS) begin
        step_reg <= step_reg + 2'h1;
      end
      last_reg <= adc_result_o;
    end
  end

  // An idle converter toggles its output so a stale value is never mistaken for a result.
  always_comb begin
    offset = wobble_i ? {14'h0000, step_reg} : 16'h0000;
    case (adc_chan_i)
      CH_TEMP:  adc_result_o = 16'h0010 + offset;
      CH_SHUNT: adc_result_o = 16'h0100 + offset;
      CH_BUS:   adc_result_o = 16'h0200 + offset;
      default:  adc_result_o = ~last_reg;
    endcase
  end
endmodule : adc_model
`default_nettype wire

// [test/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench
  import pmon_pkg::*;
;
  localparam int unsigned STEP = 4;
  logic        ref_clk_i              = 1'b0;
  logic        srst_i                 = 1'b1;
  logic        cfg_wr_i               = 1'b0;
  cfg_t        cfg_i                  = CFG_RST;
  logic [7:0]  start_delay_field_i    = 8'h00;
  logic        diag_rd_i              = 1'b0;
  logic        done_to_alert_enable_i = 1'b0;
  logic        wobble                 = 1'b0;
  logic [15:0] adc_result_i;
  meas_t       meas_o;
  logic [31:0] power_o;
  logic [47:0] energy_o;
  logic [47:0] charge_o;
  logic        accum_valid_o;
  logic        conversion_done_flag_o;
  logic        alert_o;
  chan_t       adc_chan_o;
  logic        adc_start_o;
  logic [2:0]  adc_ct_o;
  logic        busy_o;
  int          bad_count              = 0;
  int          n_tests                = 0;

  // Free running 40 MHz clock.
  always #12.5 ref_clk_i = ~ref_clk_i;

  power_monitor_conversion_sequencer #(.CYC_PER_US(1), .DELAY_STEP_CYC(STEP)) dut (
    .ref_clk_i(ref_clk_i), .srst_i(srst_i), .cfg_wr_i(cfg_wr_i), .cfg_i(cfg_i),
    .start_delay_field_i(start_delay_field_i), .diag_rd_i(diag_rd_i),
    .done_to_alert_enable_i(done_to_alert_enable_i), .adc_result_i(adc_result_i),
    .meas_o(meas_o), .power_o(power_o), .energy_o(energy_o), .charge_o(charge_o),
    .accum_valid_o(accum_valid_o), .conversion_done_flag_o(conversion_done_flag_o),
    .alert_o(alert_o), .adc_chan_o(adc_chan_o), .adc_start_o(adc_start_o), .adc_ct_o(adc_ct_o),
    .busy_o(busy_o));

  adc_model adc (
    .ref_clk_i(ref_clk_i), .srst_i(srst_i), .adc_chan_i(adc_chan_o), .adc_start_i(adc_start_o),
    .wobble_i(wobble), .adc_result_o(adc_result_i));

  // Counts a comparison and reports a mismatch at once.
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Writes the converter configuration with the fastest period on every channel.
  task automatic cfgw(input mode_t m, input logic [2:0] a, input logic [7:0] d);
    @(negedge ref_clk_i);
    cfg_i = '{mode: m, avg: a, bus_ct: 3'h0, sh_ct: 3'h0, tmp_ct: 3'h0};
    start_delay_field_i = d;
    cfg_wr_i = 1'b1;
    @(negedge ref_clk_i);
    cfg_wr_i = 1'b0;
  endtask : cfgw

  // Waits for the next conversion start and returns the cycles taken.
  task automatic wstart(output int n);
    n = 0;
    do begin
      @(negedge ref_clk_i);
      n++;
    end while (adc_start_o !== 1'b1 && n < 5000);
  endtask : wstart

  // Waits for the done flag, counting conversion starts and noting the first channel.
  task automatic wdone(output int n, output int s, output chan_t f);
    n = 0;
    s = 0;
    f = CH_NONE;
    do begin
      @(negedge ref_clk_i);
      n++;
      if (adc_start_o === 1'b1) begin
        if (s == 0) f = adc_chan_o;
        s++;
      end
    end while (conversion_done_flag_o !== 1'b1 && n < 5000);
  endtask : wdone

  // Restarts a running sequence with a start delay of three steps.
  task automatic t_delay();
    int n;
    repeat (20) @(negedge ref_clk_i);
    cfgw(MODE_CONT_ALL, 3'h0, 8'h03);
    chk(48'(busy_o), 48'h1);
    chk(48'(adc_chan_o), 48'(CH_NONE));
    wstart(n);
    chk(48'(n >= 3 * STEP && n <= 4 * STEP + 2), 48'h1);
    chk(48'(adc_ct_o), 48'h0);
    chk(48'(adc_chan_o), 48'(CH_TEMP));
    $display("delay test done");
  endtask : t_delay

  // Follows one unaveraged continuous sequence and its results.
  task automatic t_seq();
    int n;
    wstart(n);
    chk(48'(n), 48'd50);
    chk(48'(adc_chan_o), 48'(CH_SHUNT));
    chk(48'(meas_o.temp), 48'h0010);
    wstart(n);
    chk(48'(n), 48'd50);
    chk(48'(adc_chan_o), 48'(CH_BUS));
    chk(48'(meas_o.current), 48'h0100);
    wstart(n);
    chk(48'(n), 48'd51);
    chk(48'(adc_chan_o), 48'(CH_TEMP));
    chk(48'(conversion_done_flag_o), 48'h1);
    chk(48'(meas_o.vbus), 48'h0200);
    chk(48'(power_o), 48'h0000_0002_0000);
    chk(48'(accum_valid_o), 48'h1);
    chk(energy_o, 48'h0000_0002_0000);
    chk(charge_o, 48'h0000_0000_0100);
    $display("sequence test done");
  endtask : t_seq

  // Averages four sequences of varying samples.
  task automatic t_avg();
    int    n;
    int    s;
    chan_t f;
    wobble = 1'b1;
    cfgw(MODE_CONT_ALL, 3'h1, 8'h00);
    repeat (4) wstart(n);
    chk(48'(meas_o.vbus), 48'h0200);
    chk(48'(conversion_done_flag_o), 48'h0);
    chk(48'(energy_o != 48'h0), 48'h1);
    wdone(n, s, f);
    chk(48'(n >= 450 && n <= 456), 48'h1);
    repeat (2) @(negedge ref_clk_i);
    chk(48'(meas_o.temp), 48'h0011);
    chk(48'(meas_o.current), 48'h0101);
    chk(48'(meas_o.vbus), 48'h0201);
    chk(48'(power_o), 48'h0000_0002_0301);
    wobble = 1'b0;
    $display("average test done");
  endtask : t_avg

  // Runs each triggered mode once; the first write interrupts the running continuous sequence.
  task automatic t_trig();
    mode_t m [3] = '{MODE_TRIG_BUS, MODE_TRIG_CUR, MODE_TRIG_ALL};
    int    n;
    int    s;
    chan_t f;
    for (int i = 0; i < 3; i++) begin
      cfgw(m[i], 3'h0, 8'h00);
      chk(48'(conversion_done_flag_o), 48'h0);
      wdone(n, s, f);
      chk(48'(s), 48'(i + 1));
      chk(48'(f), (i == 0) ? 48'(CH_BUS) : 48'(CH_TEMP));
      repeat (2) @(negedge ref_clk_i);
      chk(48'(busy_o), 48'h0);
      chk(48'(adc_chan_o), 48'(CH_NONE));
      chk(48'(accum_valid_o), 48'h0);
    end
    $display("triggered test done");
  endtask : t_trig

  // Shutdown keeps the flag, a diagnostic read clears it, and alert follows its enable.
  task automatic t_shdn();
    int    n;
    int    s;
    chan_t f;
    cfgw(MODE_SHDN_A, 3'h0, 8'h00);
    chk(48'(conversion_done_flag_o), 48'h1);
    chk(48'(busy_o), 48'h0);
    diag_rd_i = 1'b1;
    @(negedge ref_clk_i);
    diag_rd_i = 1'b0;
    chk(48'(conversion_done_flag_o), 48'h0);
    done_to_alert_enable_i = 1'b1;
    cfgw(MODE_TRIG_BUS, 3'h0, 8'h00);
    wdone(n, s, f);
    @(negedge ref_clk_i);
    chk(48'(alert_o), 48'h1);
    done_to_alert_enable_i = 1'b0;
    repeat (2) @(negedge ref_clk_i);
    chk(48'(alert_o), 48'h0);
    chk(48'(conversion_done_flag_o), 48'h1);
    $display("shutdown test done");
  endtask : t_shdn

  // Single-channel continuous modes; the last negedge of wdone also sees the loop restart.
  task automatic t_cont();
    int    n;
    int    s;
    chan_t f;
    cfgw(MODE_CONT_BUS, 3'h0, 8'h00);
    wdone(n, s, f);
    chk(48'(s), 48'h2);
    chk(48'(f), 48'(CH_BUS));
    wstart(n);
    chk(48'(adc_chan_o), 48'(CH_BUS));
    cfgw(MODE_CONT_CUR, 3'h0, 8'h00);
    wdone(n, s, f);
    chk(48'(s), 48'h3);
    chk(48'(f), 48'(CH_TEMP));
    wstart(n);
    chk(48'(adc_chan_o), 48'(CH_SHUNT));
    cfgw(MODE_SHDN_B, 3'h0, 8'h00);
    chk(48'(busy_o), 48'h0);
    chk(48'(conversion_done_flag_o), 48'h1);
    $display("continuous channel test done");
  endtask : t_cont

  // Prints the counts and the verdict, then ends the run.
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : complete_run

  // Main sequence after a three cycle reset.
  initial begin
    repeat (3) @(negedge ref_clk_i);
    srst_i = 1'b0;
    t_delay();
    t_seq();
    t_avg();
    t_trig();
    t_shdn();
    t_cont();
    complete_run();
  end

  // Cuts a hang short well past the expected run length.
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    bad_count++;
    complete_run();
  end
endmodule : testbench
`default_nettype wire
